// >>> eye_port_pkg.sv
// Constants and sample carrier shared by the eye pattern serial port.
package eye_port_pkg;
    // Core and eye shift clock rates, in kHz
    localparam int CORE_CLK_KHZ = 200000;
    localparam int SHIFT_CLK_KHZ = 1536;
    // Whole core cycles per shift clock period, and the high phase length
    localparam int SHIFT_DIV = CORE_CLK_KHZ / SHIFT_CLK_KHZ;
    localparam int SHIFT_HIGH = SHIFT_DIV / 2;
    localparam logic [7:0] DIV_LAST = 8'(SHIFT_DIV - 1);
    localparam logic [7:0] HIGH_CYCLES = 8'(SHIFT_HIGH);
    // Word layout: sixteen bits, X byte first then Y byte
    localparam int COORD_BITS = 8;
    localparam int WORD_BITS = 2 * COORD_BITS;
    localparam logic [3:0] BIT_LAST = 4'(WORD_BITS - 1);
    localparam int WORD_MSB = WORD_BITS - 1;
    // Buffer depth
    localparam logic [1:0] BUF_DEPTH = 2'h2;
    // Reset levels of the pins
    localparam logic STROBE_IDLE = 1'b1;
    localparam logic DATA_IDLE = 1'b0;

    typedef struct packed {
        logic [COORD_BITS-1:0] eye_x_byte;
        logic [COORD_BITS-1:0] eye_y_byte;
    } eye_sample_s;

    typedef enum logic {ST_IDLE, ST_SHIFT} eye_state_e;
endpackage

// >>> eye_pattern_serial_port.sv
// Eye pattern serial port: buffers constellation samples and shifts them out.
`timescale 1ns/10ps
`default_nettype none
module eye_pattern_serial_port (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire eye_port_pkg::eye_sample_s sample_data,
    input wire logic sample_valid,
    output logic sample_ready,
    output logic eye_shift_clock,
    output logic eye_data,
    output logic eye_frame_strobe
);

    ////////////////////////////////////////////////////////////////////////////
    // Shift clock divider
    ////////////////////////////////////////////////////////////////////////////

    logic [7:0] div_cnt_q;
    logic [7:0] div_cnt_d;
    logic clk_q;
    logic clk_d;
    wire div_wrap = (div_cnt_q == eye_port_pkg::DIV_LAST);
    // Last core cycle of the high phase
    wire high_done = (div_cnt_q == eye_port_pkg::HIGH_CYCLES - 8'h01);
    // Shift clock rise and pin updates share the wrap edge
    wire shift_rise = div_wrap;

    // Integer division raises the rate slightly; the converter only needs edges
    assign div_cnt_d = div_wrap ? 8'h00 : div_cnt_q + 8'h01;

    // Set on the wrap and cleared after the high phase, so no short rise follows reset
    assign clk_d = div_wrap ? 1'b1 : (high_done ? 1'b0 : clk_q);

    // Clock is high for the first half of each period
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            div_cnt_q <= 8'h00;
            clk_q <= 1'b0;
        end else begin
            div_cnt_q <= div_cnt_d;
            clk_q <= clk_d;
        end
    end

    assign eye_shift_clock = clk_q;

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry sample buffer
    ////////////////////////////////////////////////////////////////////////////

    eye_port_pkg::eye_sample_s buf_mem [2];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] buf_cnt_q;
    logic pop;
    wire buf_full = (buf_cnt_q == eye_port_pkg::BUF_DEPTH);
    wire buf_empty = (buf_cnt_q == 2'h0);
    wire push = sample_valid && !buf_full;
    eye_port_pkg::eye_sample_s head;

    assign sample_ready = !buf_full;
    assign head = buf_mem[rd_ptr_q];

    // Storage needs no reset; the count guards it
    always_ff @(posedge core_clk) begin
        if (push) begin
            buf_mem[wr_ptr_q] <= sample_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            buf_cnt_q <= 2'h0;
        end else begin
            wr_ptr_q <= wr_ptr_q ^ push;
            rd_ptr_q <= rd_ptr_q ^ pop;
            buf_cnt_q <= buf_cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Word shifter
    ////////////////////////////////////////////////////////////////////////////

    eye_port_pkg::eye_state_e state_q;
    eye_port_pkg::eye_state_e state_d;
    logic [eye_port_pkg::WORD_MSB:0] shift_q;
    logic [eye_port_pkg::WORD_MSB:0] shift_d;
    logic [3:0] bit_cnt_q;
    logic [3:0] bit_cnt_d;
    logic strobe_q;
    logic strobe_d;
    logic data_q;
    logic data_d;
    wire last_bit = (bit_cnt_q == eye_port_pkg::BIT_LAST);

    // A word starts only on a rise out of idle, which forces one high period between words
    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        bit_cnt_d = bit_cnt_q;
        strobe_d = strobe_q;
        data_d = data_q;
        pop = 1'b0;
        case (state_q)
            eye_port_pkg::ST_IDLE: begin
                if (shift_rise && !buf_empty) begin
                    pop = 1'b1;
                    shift_d = {head.eye_x_byte, head.eye_y_byte};
                    data_d = head.eye_x_byte[eye_port_pkg::COORD_BITS-1];
                    strobe_d = 1'b0;
                    bit_cnt_d = 4'h0;
                    state_d = eye_port_pkg::ST_SHIFT;
                end
            end
            eye_port_pkg::ST_SHIFT: begin
                if (shift_rise) begin
                    if (last_bit) begin
                        strobe_d = eye_port_pkg::STROBE_IDLE;
                        data_d = eye_port_pkg::DATA_IDLE;
                        state_d = eye_port_pkg::ST_IDLE;
                    end else begin
                        shift_d = {shift_q[eye_port_pkg::WORD_MSB-1:0], 1'b0};
                        data_d = shift_q[eye_port_pkg::WORD_MSB-1];
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end
                end
            end
            default: begin
                state_d = eye_port_pkg::ST_IDLE;
            end
        endcase
    end

    // Pins come straight from flops so they move together with the clock rise
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= eye_port_pkg::ST_IDLE;
            shift_q <= 16'h0000;
            bit_cnt_q <= 4'h0;
            strobe_q <= eye_port_pkg::STROBE_IDLE;
            data_q <= eye_port_pkg::DATA_IDLE;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            bit_cnt_q <= bit_cnt_d;
            strobe_q <= strobe_d;
            data_q <= data_d;
        end
    end

    assign eye_frame_strobe = strobe_q;
    assign eye_data = data_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    ////////////////////////////////////////////////////////////////////////////

    // Rises of the shift clock seen while the strobe is low
    logic [4:0] low_rises_q;
    always_ff @(posedge core_clk) begin
        if (sys_rst || strobe_q) begin
            low_rises_q <= 5'h00;
        end else if (shift_rise) begin
            low_rises_q <= low_rises_q + 5'h01;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_strobe_on_rise: assert property ($changed(strobe_q) |-> $rose(clk_q))
        else $error("Frame strobe moved away from a shift clock rise");
    a_data_on_rise: assert property ($changed(data_q) |-> $rose(clk_q))
        else $error("Eye data moved away from a shift clock rise");
    a_strobe_low_len: assert property ($rose(strobe_q) |-> $past(low_rises_q) == 5'h0f)
        else $error("Frame strobe low for other than sixteen periods");
    a_gap_held_high: assert property ($rose(strobe_q) |-> strobe_q [*8])
        else $error("Frame strobe did not stay high between words");
    a_first_bit_msb: assert property ($fell(strobe_q) |-> data_q == $past(head.eye_x_byte[7]))
        else $error("Word did not start with X byte MSB");
    a_second_bit: assert property ($fell(strobe_q) |-> ##130 (data_q == $past(shift_q[14], 130)))
        else $error("Second bit is not the next lower bit");
    a_clk_period: assert property ($rose(clk_q) |-> ##130 $rose(clk_q))
        else $error("Shift clock period wrong");
    a_buf_refuse: assert property (buf_full |-> !sample_ready ##1 buf_cnt_q <= 2'h2)
        else $error("Buffer accepted a word while full");
    a_ready_room: assert property (buf_cnt_q < 2'h2 |-> sample_ready)
        else $error("Buffer refused a word with room left");

    // Duty cycle, idle level and word bounds of the link
    a_clk_duty: assert property ($rose(clk_q) |-> ##65 $fell(clk_q))
        else $error("Shift clock high phase has the wrong length");
    a_idle_data_low: assert property (strobe_q |-> data_q == eye_port_pkg::DATA_IDLE)
        else $error("Eye data not idle while the strobe is high");
    a_start_has_word: assert property ($fell(strobe_q) |-> $past(buf_cnt_q) != 2'h0)
        else $error("Word started with an empty buffer");
    a_word_bits: assert property ($rose(strobe_q) |-> $past(bit_cnt_q) == eye_port_pkg::BIT_LAST)
        else $error("Word ended after other than sixteen bits");
    a_gap_len: assert property ($rose(strobe_q) |-> ##129 strobe_q)
        else $error("Frame strobe gap shorter than one shift period");

    c_word_start: cover property ($fell(strobe_q));
    c_back_to_back: cover property ($rose(strobe_q) ##[1:300] $fell(strobe_q));
    c_buf_full: cover property (buf_full && sample_valid);
    c_refused_then_taken: cover property (sample_valid && !sample_ready ##1 sample_valid && sample_ready);
    c_word_end: cover property ($rose(strobe_q));

endmodule // eye_pattern_serial_port
`default_nettype wire

// >>> eye_dac_model.sv
// Behavioural model of the shift-register D/A converter fed by the eye port.
`timescale 1ns/10ps
`default_nettype none
module eye_dac_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic eye_shift_clock,
    input wire logic eye_data,
    input wire logic eye_frame_strobe,
    output logic [15:0] word_out,
    output logic word_stb,
    output logic [4:0] bit_cnt,
    output logic [15:0] low_len,
    output logic [15:0] high_len,
    output logic off_edge
);
    logic clk_q;
    logic data_q;
    logic stb_q;
    logic [15:0] run_q;
    wire logic rise = eye_shift_clock & ~clk_q;
    ////////////////////////////////////////////////////////////////////////////////
    // Pins are oversampled; the bit held before a rise is the one the rise takes
    always_ff @(posedge core_clk) begin
        clk_q <= eye_shift_clock;
        data_q <= eye_data;
        stb_q <= eye_frame_strobe;
        word_stb <= 1'b0;
        if (sys_rst) begin
            bit_cnt <= 5'h00;
            off_edge <= 1'b0;
            run_q <= 16'h0000;
            word_out <= 16'h0000;
            low_len <= 16'h0000;
            high_len <= 16'h0000;
        end else begin
            if (eye_frame_strobe != stb_q && !rise) off_edge <= 1'b1; // Strobe off a rise
            run_q <= (eye_frame_strobe != stb_q) ? 16'h0001 : run_q + 16'h0001;
            if (rise && !stb_q) begin
                word_out <= {word_out[14:0], data_q};
                bit_cnt <= bit_cnt + 5'h01;
            end
            if (eye_frame_strobe && !stb_q) begin
                word_stb <= 1'b1;
                low_len <= run_q;
            end
            if (!eye_frame_strobe && stb_q) begin
                high_len <= run_q;
                bit_cnt <= 5'h00;
            end
        end
    end
endmodule // eye_dac_model
`default_nettype wire

// >>> tb.sv
// Self-checking testbench of the eye pattern serial port.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic sample_valid = 1'b0;
    eye_port_pkg::eye_sample_s sample_data = '0;
    wire logic sample_ready, eye_shift_clock, eye_data, eye_frame_strobe, word_stb, off_edge;
    wire logic [15:0] word_out, low_len, high_len;
    wire logic [4:0] bit_cnt;
    int error_cnt = 0;
    int comparisons = 0;
    int w;
    // 200 MHz core clock
    always #2.5 core_clk = ~core_clk;
    eye_pattern_serial_port DUT (.core_clk(core_clk), .sys_rst(sys_rst),
        .sample_data(sample_data), .sample_valid(sample_valid), .sample_ready(sample_ready),
        .eye_shift_clock(eye_shift_clock), .eye_data(eye_data),
        .eye_frame_strobe(eye_frame_strobe));
    eye_dac_model dac (.core_clk(core_clk), .sys_rst(sys_rst),
        .eye_shift_clock(eye_shift_clock), .eye_data(eye_data),
        .eye_frame_strobe(eye_frame_strobe), .word_out(word_out), .word_stb(word_stb),
        .bit_cnt(bit_cnt), .low_len(low_len), .high_len(high_len), .off_edge(off_edge));
    ////////////////////////////////////////////////////////////////////////////////
    task check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Offer one sample and hold it until taken; returns cycles spent refused
    task push(input logic [7:0] x, input logic [7:0] y, output int waited);
        waited = 0;
        @(posedge core_clk);
        sample_data <= '{eye_x_byte: x, eye_y_byte: y};
        sample_valid <= 1'b1;
        @(negedge core_clk);
        while (sample_ready !== 1'b1 && waited < 5000) begin
            @(negedge core_clk);
            waited++;
        end
        check(16'(waited < 5000), 16'h0001);
        @(posedge core_clk);
        sample_valid <= 1'b0;
    endtask
    // Wait for a whole frame at the converter, bounded by 5000 core cycles
    task expect_word(input logic [15:0] exp);
        int n;
        n = 0;
        while (word_stb !== 1'b1 && n < 5000) begin
            @(negedge core_clk);
            n++;
        end
        check(16'(n < 5000), 16'h0001);
        check(word_out, exp);
        check({11'h000, bit_cnt}, 16'h0010);
        check(low_len, 16'(16 * eye_port_pkg::SHIFT_DIV));
        @(negedge core_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
        @(negedge core_clk);
        check({12'h000, eye_shift_clock, eye_data, eye_frame_strobe, sample_ready},
              16'h0003);
    endtask
    // Lone bits at the byte edges expose a swapped byte order or bits reversed within a byte
    task t_single;
        push(8'h80, 8'h01, w);
        expect_word(16'h8001);
    endtask
    // Fill both entries right after a shift clock fall so the third offer is refused
    task t_fill;
        while (eye_shift_clock !== 1'b1) @(negedge core_clk);
        while (eye_shift_clock !== 1'b0) @(negedge core_clk);
        push(8'ha5, 8'h3c, w);
        push(8'h5a, 8'hc3, w);
        @(negedge core_clk);
        check({15'h0000, sample_ready}, 16'h0000);
        push(8'hff, 8'h00, w);
        check(16'(w > 0), 16'h0001);
        expect_word(16'ha53c);
        expect_word(16'h5ac3);
        check(16'(high_len >= 16'(eye_port_pkg::SHIFT_DIV)), 16'h0001);
        expect_word(16'hff00);
        check({14'h0000, sample_ready, off_edge}, 16'h0002);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task test_done;
        $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Watchdog: the sequence needs about 9000 cycles
    initial begin
        repeat (40000) @(posedge core_clk);
        error_cnt++;
        test_done();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_single();
        t_fill();
        test_done();
    end
endmodule // tb
`default_nettype wire
